// file: hw/standby_defines.svh
// Standby controller constants: register offsets, field positions, reset values, wait counts.
// Assumes inclusion by bare name from the package and the bench.
`ifndef STANDBY_DEFINES_SVH
`define STANDBY_DEFINES_SVH

`define SB_CTRL_OFS        12'h000
`define SB_STATUS_OFS      12'h004
`define SB_TMRSEL_OFS      12'h008
`define SB_SETTLE_OFS      12'h00c
`define SB_RUNGATE_OFS     12'h010

`define SB_WAIT_SERVICE    8'h0a
`define SB_WAIT_RESUME     8'h03
`define SB_CPU_MAIN_RST    1'b1
`define SB_SETTLE_RST      8'h10
`define SB_TMRSEL_RST      7'h60

`define SB_SEL_TC16_SUB    0
`define SB_SEL_CA_PIN      1
`define SB_SEL_CB_PIN      2
`define SB_SEL_IA_CAOUT    3
`define SB_SEL_IB_SLOW     4
`define SB_SEL_SUB_ON      5
`define SB_SEL_SLOW_ON     6

`endif

// file: hw/standby_pkg.sv
// Types shared by the standby controller.
// Assumes standby_defines.svh is on the include path.
package standby_pkg;
  `include "standby_defines.svh"

  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_HALT   = 3'b001,
    ST_STOP   = 3'b011,
    ST_SETTLE = 3'b010,
    ST_WAIT   = 3'b110
  } sb_state_t;
endpackage

// file: hw/standby_mode_control.sv
// Standby controller: HALT release, STOP entry, clock and timer gating, APB registers.
// Assumes CPU core asserts one-cycle halt/stop requests and the interrupt controller gives levels.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module standby_mode_control
  import standby_pkg::*;
#(
  parameter int SETTLE_W = 8
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        halt_req_i,
  input  wire logic        stop_req_i,
  input  wire logic        irq_pending_i,
  input  wire logic        irq_mask_flag_i,
  input  wire logic        irq_priority_flag_i,
  input  wire logic        global_irq_enable_i,
  input  wire logic        in_service_priority_flag_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             cpu_clk_en_o,
  output logic             flash_en_o,
  output logic             main_osc_en_o,
  output logic             ext_main_clk_en_o,
  output logic             sub_osc_en_o,
  output logic             slow_osc_en_o,
  output logic             cpu_resume_o,
  output logic             cpu_vector_o,
  output logic             cpu_reset_vector_o,
  output logic             tc16_run_o,
  output logic             counter_a_run_o,
  output logic             counter_b_run_o,
  output logic             counter_c_run_o,
  output logic             itimer_a_run_o,
  output logic             itimer_b_run_o,
  output logic             itimer_c_run_o,
  output logic             rtc_run_o
);
  import standby_pkg::*;

  typedef struct packed {
    // Sequencing
    sb_state_t             state;
    logic [SETTLE_W-1:0]   count;
    logic                  service;

    // Software settings and STOP fallback status
    logic                  cpu_main;
    logic [6:0]            tmrsel;
    logic [SETTLE_W-1:0]   settle;
    logic                  stop_fallback;

    // Bus answer and registered outputs
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  cpu_clk_en;
    logic                  flash_en;
    logic                  main_osc_en;
    logic                  ext_main_clk_en;
    logic                  sub_osc_en;
    logic                  slow_osc_en;
    logic                  resume;
    logic                  vector;
    logic                  rst_vec;
    logic [7:0]            run_gate;
  } sb_regs_t;

  sb_regs_t r;
  sb_regs_t next_r;
  logic     wake;
  logic     serve;
  logic     apb_acc;

  // Decision per interrupt table
  function automatic logic irq_serviced(input logic ie, input logic pr, input logic in_service_priority_flag);
    irq_serviced = ie && (!pr || in_service_priority_flag);
  endfunction

  // Release wait, lower figure of each pair
  function automatic logic [SETTLE_W-1:0] wait_len(input logic svc);
    if (svc) begin
      wait_len = SETTLE_W'(`SB_WAIT_SERVICE);
    end else begin
      wait_len = SETTLE_W'(`SB_WAIT_RESUME);
    end
  endfunction

  // Word offset match
  function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] ofs);
    addr_is = (addr == ofs);
  endfunction

  // Timer run enables while STOP holds
  function automatic logic [6:0] stop_gates(input logic [6:0] sel);
    logic [6:0] g;
    g = 7'h00;
    g[0] = sel[`SB_SEL_TC16_SUB] && sel[`SB_SEL_SUB_ON];
    g[1] = sel[`SB_SEL_CA_PIN];
    g[2] = sel[`SB_SEL_CB_PIN];
    g[3] = 1'b0;
    g[4] = sel[`SB_SEL_IA_CAOUT] && sel[`SB_SEL_CA_PIN];
    g[5] = sel[`SB_SEL_IB_SLOW] && sel[`SB_SEL_SLOW_ON];
    g[6] = 1'b0;
    stop_gates = g;
  endfunction

  // Register image after reset
  function automatic sb_regs_t reset_regs();
    sb_regs_t v;
    v = '0;
    v.state = ST_RUN;
    v.cpu_main = `SB_CPU_MAIN_RST;
    v.settle = SETTLE_W'(`SB_SETTLE_RST);
    v.tmrsel = `SB_TMRSEL_RST;
    v.sub_osc_en = 1'b1;
    v.slow_osc_en = 1'b1;
    v.cpu_clk_en = 1'b1;
    v.flash_en = 1'b1;
    v.main_osc_en = 1'b1;
    v.ext_main_clk_en = 1'b1;
    v.run_gate = 8'hff;
    reset_regs = v;
  endfunction

  always_comb begin
    next_r = r;
    wake = irq_pending_i && !irq_mask_flag_i;
    serve = irq_serviced(global_irq_enable_i, irq_priority_flag_i, in_service_priority_flag_i);
    apb_acc = psel_i && penable_i && !r.pready;
    next_r.resume = 1'b0;
    next_r.vector = 1'b0;
    next_r.rst_vec = 1'b0;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;

    case (r.state)
      // Running: take a halt or stop pulse
      ST_RUN: begin
        if (stop_req_i && r.cpu_main) begin
          if (wake) begin
            next_r.state = ST_SETTLE;
            next_r.stop_fallback = 1'b1;
            next_r.count = r.settle;
            next_r.service = serve;
          end else begin
            next_r.state = ST_STOP;
          end
        end else if (halt_req_i) begin
          next_r.state = ST_HALT;
        end
      end

      // Halted: any unmasked request releases
      ST_HALT: begin
        if (wake) begin
          next_r.state = ST_WAIT;
          next_r.service = serve;
          next_r.count = wait_len(serve);
        end
      end

      // Stopped: request starts the settle count
      ST_STOP: begin
        if (wake) begin
          next_r.state = ST_SETTLE;
          next_r.stop_fallback = 1'b0;
          next_r.count = r.settle;
          next_r.service = serve;
        end
      end

      // Oscillator settle time
      ST_SETTLE: begin
        if (r.count <= SETTLE_W'(1)) begin
          next_r.state = ST_WAIT;
          next_r.count = wait_len(r.service);
        end else begin
          next_r.count = r.count - SETTLE_W'(1);
        end
      end

      // Release wait, then resume pulse
      ST_WAIT: begin
        if (r.count <= SETTLE_W'(1)) begin
          next_r.state = ST_RUN;
          next_r.resume = 1'b1;
          next_r.vector = r.service;
        end else begin
          next_r.count = r.count - SETTLE_W'(1);
        end
      end
      default: begin
        next_r.state = ST_RUN;
      end
    endcase

    // CPU, flash and main clock gating follows the next state so outputs track it registered; sub and slow enables follow tmrsel
    next_r.cpu_clk_en = (next_r.state == ST_RUN);
    next_r.flash_en = (next_r.state != ST_STOP);
    next_r.main_osc_en = (next_r.state != ST_STOP);
    next_r.ext_main_clk_en = (next_r.state != ST_STOP);
    next_r.sub_osc_en = r.tmrsel[`SB_SEL_SUB_ON];
    next_r.slow_osc_en = r.tmrsel[`SB_SEL_SLOW_ON];

    // Timers run freely outside STOP
    if (next_r.state == ST_STOP) begin
      next_r.run_gate[6:0] = stop_gates(r.tmrsel);
    end else begin
      next_r.run_gate[6:0] = 7'h7f;
    end
    next_r.run_gate[7] = 1'b1;

    // APB slave, one wait state
    if (apb_acc) begin
      next_r.pready = 1'b1;
      next_r.prdata = 32'h0000_0000;
      if (addr_is(paddr_i, `SB_CTRL_OFS)) begin
        if (pwrite_i) begin
          next_r.cpu_main = pwdata_i[0];
        end
        next_r.prdata = {31'h0, r.cpu_main};
      end else if (addr_is(paddr_i, `SB_STATUS_OFS)) begin
        next_r.prdata = {28'h0, r.stop_fallback, r.state};
      end else if (addr_is(paddr_i, `SB_TMRSEL_OFS)) begin
        if (pwrite_i) begin
          next_r.tmrsel = pwdata_i[6:0];
        end
        next_r.prdata = {25'h0, r.tmrsel};
      end else if (addr_is(paddr_i, `SB_SETTLE_OFS)) begin
        if (pwrite_i) begin
          next_r.settle = pwdata_i[SETTLE_W-1:0];
        end
        next_r.prdata = 32'(r.settle);
      end else if (addr_is(paddr_i, `SB_RUNGATE_OFS)) begin
        next_r.prdata = {24'h0, r.run_gate};
      end else begin
        next_r.pslverr = 1'b1;
      end
    end


    // Reset leaves any standby state
    if (rst_i) begin
      next_r = reset_regs();
      next_r.rst_vec = r.state != ST_RUN || !r.cpu_clk_en;
    end
  end

  always_ff @(posedge core_clk_i) begin
    r <= next_r;
  end

  // Bus answer
  assign prdata_o = r.prdata;
  assign pready_o = r.pready;
  assign pslverr_o = r.pslverr;

  // Clock and oscillator enables
  assign cpu_clk_en_o = r.cpu_clk_en;
  assign flash_en_o = r.flash_en;
  assign main_osc_en_o = r.main_osc_en;
  assign ext_main_clk_en_o = r.ext_main_clk_en;
  assign sub_osc_en_o = r.sub_osc_en;
  assign slow_osc_en_o = r.slow_osc_en;

  // CPU restart strobes
  assign cpu_resume_o = r.resume;
  assign cpu_vector_o = r.vector;
  assign cpu_reset_vector_o = r.rst_vec;

  // Timer run enables
  assign tc16_run_o = r.run_gate[0];
  assign counter_a_run_o = r.run_gate[1];
  assign counter_b_run_o = r.run_gate[2];
  assign counter_c_run_o = r.run_gate[3];
  assign itimer_a_run_o = r.run_gate[4];
  assign itimer_b_run_o = r.run_gate[5];
  assign itimer_c_run_o = r.run_gate[6];
  assign rtc_run_o = r.run_gate[7];
endmodule

// file: tb/standby_chk_props.sv
// Port assertions for the standby controller.
// Assumes binding to standby_mode_control, one clock.
`timescale 1ns/100ps
module standby_chk (
  input wire logic core_clk_i, rst_i, halt_req_i, irq_mask_flag_i, irq_priority_flag_i, psel_i,
  input wire logic global_irq_enable_i, in_service_priority_flag_i, penable_i, pready_o, cpu_clk_en_o,
  input wire logic flash_en_o, main_osc_en_o, ext_main_clk_en_o, sub_osc_en_o, slow_osc_en_o,
  input wire logic cpu_resume_o, cpu_vector_o, counter_c_run_o, itimer_c_run_o, rtc_run_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_stop; !main_osc_en_o; endsequence
  sequence s_acc; psel_i && penable_i && !pready_o; endsequence
  property p_halt; halt_req_i && cpu_clk_en_o |-> ##[1:2] !cpu_clk_en_o; endproperty
  property p_mask; (!cpu_clk_en_o && irq_mask_flag_i) [*4] |-> !cpu_resume_o; endproperty
  property p_vec; cpu_vector_o |-> cpu_resume_o; endproperty
  property p_serve; cpu_resume_o |->
    cpu_vector_o == (global_irq_enable_i && (!irq_priority_flag_i || in_service_priority_flag_i)); endproperty
  property p_gate; s_stop |-> !flash_en_o && !ext_main_clk_en_o && !cpu_clk_en_o; endproperty
  property p_keep; s_stop ##0 $past(!main_osc_en_o) |-> $stable({sub_osc_en_o, slow_osc_en_o}); endproperty
  property p_third; s_stop |-> !counter_c_run_o && !itimer_c_run_o; endproperty
  property p_rtc; rtc_run_o; endproperty
  property p_apb; s_acc |=> pready_o ##1 !pready_o; endproperty
  a_halt: assert property (p_halt) else $error("halt entry not gated");
  a_mask: assert property (p_mask) else $error("masked request resumed");
  a_vec: assert property (p_vec) else $error("vector without resume");
  a_serve: assert property (p_serve) else $error("wrong vector choice");
  a_gate: assert property (p_gate) else $error("stop gating wrong");
  a_keep: assert property (p_keep) else $error("retained clocks changed");
  a_third: assert property (p_third) else $error("third units running");
  a_rtc: assert property (p_rtc) else $error("rtc stopped");
  a_apb: assert property (p_apb) else $error("apb ready wrong");
endmodule
bind standby_mode_control standby_chk u_chk (.*);

// file: tb/cpu_side_model.sv
// Model of the CPU core and interrupt controller.
// Assumes one caller; drives right after a rising edge.
`timescale 1ns/100ps
module cpu_side_model (
  input  wire logic clk_i,
  output logic      halt_o, stop_o, pend_o, mask_o, prio_o, ien_o, isp_o
);
  initial {halt_o, stop_o, pend_o, mask_o, prio_o, ien_o, isp_o} = 7'h08;
  task automatic instr(input logic h, input logic s);
    @(posedge clk_i);
    halt_o <= h;
    stop_o <= s;
    @(posedge clk_i);
    halt_o <= 1'b0;
    stop_o <= 1'b0;
  endtask
  // Bits: pending, mask, priority, enable, in-service
  task automatic irq(input logic [4:0] v);
    @(posedge clk_i);
    {pend_o, mask_o, prio_o, ien_o, isp_o} <= v;
  endtask
endmodule

// file: tb/test_standby_mode_control.sv
// Bench for the standby controller.
// Assumes the partner model drives the CPU side.
`timescale 1ns/100ps
`include "standby_defines.svh"
module test_standby_mode_control;
  logic        core_clk_i, rst_i, psel_i, penable_i, pwrite_i, ok;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, rd;
  wire logic [31:0] prdata_o;
  wire logic   pready_o, pslverr_o, cpu_clk_en_o, flash_en_o, main_osc_en_o, ext_main_clk_en_o, sub_osc_en_o;
  wire logic   slow_osc_en_o, cpu_resume_o, cpu_vector_o, cpu_reset_vector_o, tc16_run_o, counter_a_run_o;
  wire logic   counter_b_run_o, counter_c_run_o, itimer_a_run_o, itimer_b_run_o, itimer_c_run_o, rtc_run_o;
  wire logic   halt_req_i, stop_req_i, irq_pending_i, irq_mask_flag_i, irq_priority_flag_i;
  wire logic   global_irq_enable_i, in_service_priority_flag_i;
  int          n_errors, check_count, n, cyc;
  standby_mode_control dut (.*);
  cpu_side_model m (.clk_i(core_clk_i), .halt_o(halt_req_i), .stop_o(stop_req_i), .pend_o(irq_pending_i),
    .mask_o(irq_mask_flag_i), .prio_o(irq_priority_flag_i), .ien_o(global_irq_enable_i),
    .isp_o(in_service_priority_flag_i));
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    ok = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask
  task wres();
    for (n = 0; cpu_resume_o !== 1'b1 && n < 40; n++) @(posedge core_clk_i);
  endtask
  task t_halt(input logic [4:0] v, input int w);
    m.instr(1'b1, 1'b0);
    repeat (3) @(posedge core_clk_i);
    m.irq(v);
    wres();
    if (w == 0) begin
      chk(n, 40);
      m.irq(5'h10);
      wres();
    end else begin
      chk(n >= w && n <= w + 3, 1);
      chk(cpu_vector_o, v[1] & (!v[2] | v[0]));
    end
    m.irq(5'h08);
  endtask
  task t_stop(input logic [31:0] s);
    apb(1'b1, `SB_TMRSEL_OFS, s);
    m.instr(1'b0, 1'b1);
    repeat (4) @(posedge core_clk_i);
    chk({main_osc_en_o, flash_en_o, ext_main_clk_en_o, cpu_clk_en_o}, 0);
    chk({sub_osc_en_o, slow_osc_en_o}, {s[5], s[6]});
    chk({tc16_run_o, counter_a_run_o, counter_b_run_o, itimer_a_run_o, itimer_b_run_o},
      {s[0] & s[5], s[1], s[2], s[3] & s[1], s[4] & s[6]});
    chk({counter_c_run_o, itimer_c_run_o, rtc_run_o}, 1);
    m.irq(5'h10);
    wres();
    chk(n >= 7 && n <= 12, 1);
    m.irq(5'h08);
  endtask
  initial begin
    core_clk_i = 0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  initial begin
    for (cyc = 0; cyc < 20000; cyc++) @(posedge core_clk_i);
    n_errors++;
    results();
  end
  initial begin
    {rst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = {1'b1, 47'h0};
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    apb(1'b0, `SB_CTRL_OFS, 0);
    chk(rd, 1);
    apb(1'b0, `SB_TMRSEL_OFS, 0);
    chk(rd, 32'h60);
    apb(1'b0, 12'h014, 0);
    chk({ok, rd}, 33'h100000000);
    t_halt(5'h18, 0);
    t_halt(5'h10, 3);
    t_halt(5'h12, 10);
    t_halt(5'h16, 3);
    t_halt(5'h17, 10);
    apb(1'b1, `SB_SETTLE_OFS, 4);
    t_stop(32'h7f);
    t_stop(32'h0d);
    apb(1'b1, `SB_CTRL_OFS, 0);
    m.instr(1'b0, 1'b1);
    repeat (4) @(posedge core_clk_i);
    chk({main_osc_en_o, cpu_clk_en_o}, 2'b11);
    apb(1'b1, `SB_CTRL_OFS, 1);
    m.irq(5'h10);
    m.instr(1'b0, 1'b1);
    repeat (2) @(posedge core_clk_i);
    chk(main_osc_en_o, 1);
    wres();
    chk(n <= 12, 1);
    m.irq(5'h08);
    m.instr(1'b1, 1'b0);
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b1;
    ok = 0;
    repeat (4) @(posedge core_clk_i) ok |= cpu_reset_vector_o;
    rst_i <= 1'b0;
    chk(ok, 1);
    repeat (3) @(posedge core_clk_i);
    chk(cpu_clk_en_o, 1);
    results();
  end
  task results();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
endmodule
